// [rtl/dcrd_top.sv]
/*
 Channel resume and next descriptor pointer slice of a 24 channel DMA.
 Assumes suspend requests, fetch requests and enables come from logic
 on core_clk; each fetch port is served by the system interconnect.
*/
// Functional notes
// [RULE1] One write-only resume bit per channel 0..23, bit equals channel.
// [RULE2] Writing 1 resumes that channel's read and write requests; 0 does nothing.
// [RULE3] Per-channel read/write pointer at 0x68 plus 0x40 per channel, reset zero.
// [RULE4] The 30-bit pointer field gives fetch address bits 31 down to 2.
// [RULE5] Descriptors are word aligned; pointer bits 1:0 are ignored for fetch.
// [RULE6] Select bit 0 clear fetches the descriptor through interface 0.
// [RULE7] Select bit 0 set fetches the descriptor through interface 1.
// [RULE8] No descriptor fetch unless the channel's fetch enable is set.
// [RULE9] Resume bits of channels not suspended change nothing.
`timescale 1ns/100ps
module dcrd_top
   import dcrd_pkg::*;
(
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic              ce,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [DATA_W-1:0] avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic      [DATA_W-1:0] avs_readdata,
   output logic                   avs_waitrequest,
   // Channel suspend state
   input  wire logic [NCH-1:0]    chan_suspend_req,
   output logic      [NCH-1:0]    chan_suspended,
   output logic      [NCH-1:0]    chan_resume_pulse,
   // Descriptor fetch requests
   input  wire logic [NCH-1:0]    desc_fetch_req,
   input  wire logic [NCH-1:0]    next_descriptor_fetch_enable,
   output logic      [NCH-1:0]    fetch_pending,
   // Fetch interface 0
   output logic                   fetch0_valid,
   output logic      [DATA_W-1:0] fetch0_addr,
   output logic      [CH_W-1:0]   fetch0_chan,
   input  wire logic              fetch0_ready,
   // Fetch interface 1
   output logic                   fetch1_valid,
   output logic      [DATA_W-1:0] fetch1_addr,
   output logic      [CH_W-1:0]   fetch1_chan,
   input  wire logic              fetch1_ready
);
   // ==========================================================
   // Declarations
   dcrd_bus_st_t      state;
   logic [31:0]       ndp [NCH];
   logic              req;
   logic              wr_fire;
   logic              hit_resume;
   logic              hit_ndp;
   logic [ADDR_W-1:0] ndp_off;
   logic [CH_W-1:0]   ndp_idx;
   logic [31:0]       be_mask;
   logic [NCH-1:0]    resume_bits;
   logic              resume_wr;
   logic [31:0]       next_rdata;
   logic [NCH-1:0]    cand;
   logic [NCH-1:0]    grant;
   logic              grant_any;
   logic [CH_W-1:0]   gidx;
   logic              gport;
   logic [NDA_W-1:0]  load_nda;
   logic              load0;
   logic              load1;

   dcrd_fetch_if fif0 ();
   dcrd_fetch_if fif1 ();

   // ==========================================================
   // Bus slave, one wait state per access
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ((state != ST_RESP) | ~ce);
   assign wr_fire         = ce & avs_write & (state == ST_RESP);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
      end else if (ce) begin
         case (state)
            ST_IDLE: begin
               if (req) begin
                  state <= ST_RESP;
               end
            end
            ST_RESP: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Address decode
   // [RULE3] pointer window decode
   assign ndp_off    = avs_address - NDP_BASE;
   assign ndp_idx    = ndp_off[10:6];
   assign hit_ndp    = (avs_address >= NDP_BASE) && (ndp_off[5:0] == 6'h00)
                       && (ndp_off[11:6] < 6'(NCH));
   // [RULE1] global resume decode
   assign hit_resume = (avs_address == RESUME_OFS);

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         be_mask[8*b +: 8] = {8{avs_byteenable[b]}};
      end
   end

   // [RULE1] bit position equals channel
   assign resume_bits = avs_writedata[NCH-1:0] & be_mask[NCH-1:0];
   assign resume_wr   = wr_fire & hit_resume;

   // ==========================================================
   // Read data, captured while waitrequest is high
   always_comb begin
      next_rdata = 32'h00000000;
      if (hit_ndp) begin
         next_rdata = ndp[ndp_idx];
      end else if (avs_address == SUSP_OFS) begin
         next_rdata = {8'h00, chan_suspended};
      end else if (avs_address == PEND_OFS) begin
         next_rdata = {8'h00, fetch_pending};
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         avs_readdata <= 32'h00000000;
      end else if (ce && avs_read && state == ST_IDLE) begin
         avs_readdata <= next_rdata;
      end
   end

   // ==========================================================
   // Suspend state and resume
   // Suspend request wins over a resume in the same cycle
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         chan_suspended    <= CH_RESET;
         chan_resume_pulse <= CH_RESET;
      end else if (ce) begin
         // [RULE2] clear suspend on written ones
         if (resume_wr) begin
            chan_suspended <= (chan_suspended & ~resume_bits) | chan_suspend_req;
         end else begin
            chan_suspended <= chan_suspended | chan_suspend_req;
         end
         // [RULE9] only suspended channels resume
         chan_resume_pulse <= resume_wr ? (resume_bits & chan_suspended) : CH_RESET;
      end
   end

   // ==========================================================
   // Next descriptor pointers
   // [RULE3] byte-lane writes, bit 1 reads zero
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         for (int c = 0; c < NCH; c++) begin
            ndp[c] <= NDP_RESET;
         end
      end else if (ce && wr_fire && hit_ndp) begin
         ndp[ndp_idx] <= ((ndp[ndp_idx] & ~be_mask) | (avs_writedata & be_mask)) & NDP_MASK;
      end
   end

   // ==========================================================
   // Fetch requests and launch
   // Pending flag set wins over the grant clear
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fetch_pending <= CH_RESET;
      end else if (ce) begin
         // [RULE8] only enabled channels queue
         fetch_pending <= (fetch_pending & ~(grant & {NCH{grant_any}}))
                          | (desc_fetch_req & next_descriptor_fetch_enable);
      end
   end

   // [RULE8] enable gates every launch
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         cand[c] = fetch_pending[c] & next_descriptor_fetch_enable[c]
                   & ~(ndp[c][PORT_SEL] ? fif1.busy : fif0.busy);
      end
   end

   dcrd_fetch_arb u_arb (
      .cand  (cand),
      .grant (grant),
      .any   (grant_any)
   );

   always_comb begin
      gidx = '0;
      for (int c = 0; c < NCH; c++) begin
         if (grant[c]) begin
            gidx = CH_W'(c);
         end
      end
   end

   // [RULE4] pointer bits 31:2 form the address
   assign load_nda = ndp[gidx][31:NDA_LSB];
   assign gport    = ndp[gidx][PORT_SEL];
   // [RULE6] select clear goes to interface 0
   assign load0    = grant_any & ~gport;
   // [RULE7] select set goes to interface 1
   assign load1    = grant_any & gport;

   assign fif0.load = load0;
   assign fif0.next_descriptor_address  = load_nda;
   assign fif0.chan = gidx;
   assign fif1.load = load1;
   assign fif1.next_descriptor_address  = load_nda;
   assign fif1.chan = gidx;

   dcrd_fetch_port u_port0 (
      .core_clk    (core_clk),
      .nrst        (nrst),
      .ce          (ce),
      .fif         (fif0),
      .fetch_valid (fetch0_valid),
      .fetch_addr  (fetch0_addr),
      .fetch_chan  (fetch0_chan),
      .fetch_ready (fetch0_ready)
   );

   dcrd_fetch_port u_port1 (
      .core_clk    (core_clk),
      .nrst        (nrst),
      .ce          (ce),
      .fif         (fif1),
      .fetch_valid (fetch1_valid),
      .fetch_addr  (fetch1_addr),
      .fetch_chan  (fetch1_chan),
      .fetch_ready (fetch1_ready)
   );

   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   a_resume_only_susp: assert property ( // [RULE9]
      resume_wr |=> chan_resume_pulse == ($past(resume_bits) & $past(chan_suspended)))
      else $error("resume pulse on a channel that was not suspended");

   a_resume_clears_susp: assert property ( // [RULE2]
      resume_wr |=> (chan_suspended & $past(resume_bits) & ~$past(chan_suspend_req)) == 24'h000000)
      else $error("written resume bit left channel suspended");

   a_zero_bit_keeps: assert property ( // [RULE2]
      resume_wr |=> ((chan_suspended ^ $past(chan_suspended)) & ~$past(resume_bits)
                    & ~$past(chan_suspend_req)) == 24'h000000)
      else $error("zero resume bit changed a channel");

   a_resume_reads_zero: assert property ( // [RULE1]
      (ce && avs_read && hit_resume && state == ST_IDLE) |=> avs_readdata == 32'h00000000)
      else $error("write-only resume register read nonzero");

   a_ndp_write_store: assert property ( // [RULE3]
      (wr_fire && hit_ndp && avs_byteenable == 4'hF)
      |=> ndp[$past(ndp_idx)] == ($past(avs_writedata) & NDP_MASK))
      else $error("pointer write not stored");

   a_fetch0_addr: assert property ( // [RULE4]
      (ce && load0 && !fetch0_valid) |=> fetch0_valid && fetch0_addr[31:2] == $past(load_nda))
      else $error("fetch address differs from pointer field");

   a_fetch_aligned: assert property ( // [RULE5]
      (fetch0_valid || fetch1_valid) |-> (fetch0_addr[1:0] == 2'b00 && fetch1_addr[1:0] == 2'b00))
      else $error("descriptor fetch address not word aligned");

   a_port0_select: assert property ( // [RULE6]
      load0 |-> !ndp[gidx][PORT_SEL] && !load1)
      else $error("interface 0 used with select set");

   a_port1_select: assert property ( // [RULE7]
      (ce && load1 && !fetch1_valid) |=> fetch1_valid && fetch1_chan == $past(gidx) && !$rose(fetch0_valid))
      else $error("interface 1 launch missing");

   a_fetch_needs_en: assert property ( // [RULE8]
      grant_any |-> next_descriptor_fetch_enable[gidx] && fetch_pending[gidx])
      else $error("fetch launched without enable");

   a_bus_one_wait: assert property (
      (ce && req && state == ST_IDLE) |=> state == ST_RESP)
      else $error("bus answer late");

   c_resume_susp:  cover property (resume_wr && (resume_bits & chan_suspended) != 24'h000000);
   c_fetch_port1:  cover property (fetch1_valid && fetch1_ready);
   c_both_busy:    cover property (fetch0_valid && fetch1_valid);
   c_ndp_write:    cover property (wr_fire && hit_ndp);
endmodule

// [rtl/dcrd_pkg.sv]
/*
 Constants and types of the channel resume and descriptor pointer slice.
 Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package dcrd_pkg;
   // ==========================================================
   // Sizes
   localparam int          NCH        = 24;
   localparam int          CH_W       = 5;
   localparam int          ADDR_W     = 12;
   localparam int          DATA_W     = 32;
   localparam int          NDA_W      = 30;
   // ==========================================================
   // Register map
   localparam logic [11:0] RESUME_OFS = 12'h034;
   localparam logic [11:0] SUSP_OFS   = 12'h038;
   localparam logic [11:0] PEND_OFS   = 12'h03C;
   localparam logic [11:0] NDP_BASE   = 12'h068;
   localparam int          NDP_SHIFT  = 6;
   // ==========================================================
   // Fields and reset values
   localparam int          NDA_LSB    = 2;
   localparam int          PORT_SEL   = 0;
   localparam logic [31:0] NDP_MASK   = 32'hFFFFFFFD;
   localparam logic [31:0] NDP_RESET  = 32'h00000000;
   localparam logic [23:0] CH_RESET   = 24'h000000;
   // ==========================================================
   // Bus slave states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RESP = 2'b10
   } dcrd_bus_st_t;
endpackage

// [rtl/dcrd_fetch_if.sv]
/*
 Carrier between the slice and one descriptor fetch port.
 Assumes both ends share core_clk.
*/
`timescale 1ns/100ps
interface dcrd_fetch_if;
   logic        load;
   logic [29:0] next_descriptor_address;
   logic [4:0]  chan;
   logic        busy;
   modport ctrl (output load, output next_descriptor_address, output chan, input busy);
   modport port (input load, input next_descriptor_address, input chan, output busy);
endinterface

// [rtl/dcrd_fetch_arb.sv]
/*
 Fixed priority pick among candidate channels, lowest index first.
 Assumes candidates already exclude busy ports.
*/
`timescale 1ns/100ps
module dcrd_fetch_arb
   import dcrd_pkg::*;
(
   // Candidates
   input  wire logic [NCH-1:0] cand,
   // Pick
   output logic      [NCH-1:0] grant,
   output logic                any
);
   logic [NCH:0] lower;

   assign lower[0] = 1'b0;
   assign any      = lower[NCH];

   genvar i;
   generate
      for (i = 0; i < NCH; i++) begin : g_pick
         assign lower[i+1] = lower[i] | cand[i];
         assign grant[i]   = cand[i] & ~lower[i];
      end
   endgenerate
endmodule

// [rtl/dcrd_fetch_port.sv]
/*
 One descriptor fetch request slot toward a system bus interface.
 Assumes fetch_ready comes from logic on core_clk.
*/
`timescale 1ns/100ps
module dcrd_fetch_port
   import dcrd_pkg::*;
(
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic              ce,
   // From the slice
   dcrd_fetch_if.port             fif,
   // Toward the interconnect
   output logic                   fetch_valid,
   output logic      [DATA_W-1:0] fetch_addr,
   output logic      [CH_W-1:0]   fetch_chan,
   input  wire logic              fetch_ready
);
   // ==========================================================
   // Request slot
   assign fif.busy = fetch_valid;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fetch_valid <= 1'b0;
         fetch_addr  <= NDP_RESET;
         fetch_chan  <= '0;
      end else if (ce) begin
         if (fif.load && !fetch_valid) begin
            fetch_valid <= 1'b1;
            // [RULE5] word aligned address
            fetch_addr  <= {fif.next_descriptor_address, 2'b00};
            fetch_chan  <= fif.chan;
         end else if (fetch_ready) begin
            fetch_valid <= 1'b0;
         end
      end
   end
endmodule

// [bench/dcrd_icx_model.sv]
/*
 Behavioural system interconnect serving one descriptor fetch port.
 Assumes valid is held until ready is seen high on core_clk.
*/
`timescale 1ns/100ps
module dcrd_icx_model #(
   parameter logic [31:0] SEED = 32'h0000ACE1
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic nrst,
   // Fetch port
   input  wire logic valid,
   output logic      ready
);
   logic [31:0] lfsr;
   logic [1:0]  wait_cnt;
   // ==========================================================
   // Acceptance
   // Random stall of 0..3 cycles, so prompt and slow answers both occur
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ready <= 1'b0;
         wait_cnt <= 2'h0;
         lfsr <= SEED;
      end else if (ready) begin
         ready <= 1'b0;
         lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
         wait_cnt <= lfsr[1:0];
      end else if (valid) begin
         if (wait_cnt == 2'h0) begin
            ready <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt - 2'h1;
         end
      end
   end
endmodule

// [bench/dcrd_top_tb_top.sv]
/*
 Self-checking bench of the channel resume and descriptor pointer slice.
 Assumes the package and the fetch carrier are compiled before it.
*/
`timescale 1ns/100ps
module dcrd_top_tb_top;
   import dcrd_pkg::*;
   // ==========================================================
   // Signals
   logic              core_clk, nrst, ce;
   logic [ADDR_W-1:0] avs_address;
   logic              avs_read, avs_write, avs_waitrequest;
   logic [DATA_W-1:0] avs_writedata, avs_readdata;
   logic [3:0]        avs_byteenable;
   logic [NCH-1:0]    chan_suspend_req, chan_suspended, chan_resume_pulse;
   logic [NCH-1:0]    desc_fetch_req, next_descriptor_fetch_enable, fetch_pending;
   logic              fetch0_valid, fetch0_ready, fetch1_valid, fetch1_ready;
   logic [DATA_W-1:0] fetch0_addr, fetch1_addr, f_addr, d, m, w;
   logic [CH_W-1:0]   fetch0_chan, fetch1_chan, f_chan;
   logic              f_port;
   logic [NCH-1:0]    pulse_acc;
   logic [31:0]       rs;
   int                err_count, compares, nfetch, n0, i, k;
   // ==========================================================
   // Design and far side
   dcrd_top dut_u (
      .core_clk(core_clk), .nrst(nrst), .ce(ce), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .chan_suspend_req(chan_suspend_req),
      .chan_suspended(chan_suspended), .chan_resume_pulse(chan_resume_pulse),
      .desc_fetch_req(desc_fetch_req), .fetch_pending(fetch_pending),
      .next_descriptor_fetch_enable(next_descriptor_fetch_enable),
      .fetch0_valid(fetch0_valid), .fetch0_addr(fetch0_addr), .fetch0_chan(fetch0_chan),
      .fetch0_ready(fetch0_ready), .fetch1_valid(fetch1_valid), .fetch1_addr(fetch1_addr),
      .fetch1_chan(fetch1_chan), .fetch1_ready(fetch1_ready));
   dcrd_icx_model #(.SEED(32'h0000ACE1)) icx0_u (
      .core_clk(core_clk), .nrst(nrst), .valid(fetch0_valid), .ready(fetch0_ready));
   dcrd_icx_model #(.SEED(32'h00BEEF55)) icx1_u (
      .core_clk(core_clk), .nrst(nrst), .valid(fetch1_valid), .ready(fetch1_ready));
   // ==========================================================
   // Clock, monitor, watchdog
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Looked at before the edge, where the edge itself samples
   always @(negedge core_clk) begin
      pulse_acc |= chan_resume_pulse;
      if (fetch0_valid && fetch0_ready) begin
         f_port = 1'b0;
         f_addr = fetch0_addr;
         f_chan = fetch0_chan;
         nfetch++;
      end
      if (fetch1_valid && fetch1_ready) begin
         f_port = 1'b1;
         f_addr = fetch1_addr;
         f_chan = fetch1_chan;
         nfetch++;
      end
   end
   initial begin
      #400000;
      err_count++;
      wrap_up();
   end
   // ==========================================================
   // Helpers
   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   function automatic logic [11:0] ptr(input int n);
      return NDP_BASE + 12'(n << NDP_SHIFT);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      // Held until the edge that sees waitrequest low; only the watchdog ends a hang
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] q;
      bus(1'b1, a, wd, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h00000000, q);
      chk(q, exp);
   endtask
   task automatic pulse_req(input logic [NCH-1:0] r);
      @(posedge core_clk);
      desc_fetch_req <= r;
      @(posedge core_clk);
      desc_fetch_req <= '0;
   endtask
   task automatic wrap_up();
      $display("Counts: compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      rs = 32'h000018C7;
      nrst = 1'b0;
      ce = 1'b1;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      avs_byteenable = 4'hF;
      chan_suspend_req = '0;
      desc_fetch_req = '0;
      next_descriptor_fetch_enable = 24'hFFFFFF;
      pulse_acc = '0;
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      for (i = 0; i < NCH; i++) rd(ptr(i), NDP_RESET);
      rd(RESUME_OFS, 32'h00000000);
      // Unmapped hole swallows writes
      wr(12'h004, 32'hFFFFFFFF);
      rd(12'h004, 32'h00000000);
      // Suspend, then partial resume; first round resumes everything
      for (i = 0; i < 8; i++) begin
         m = xs() >> 8;
         w = (i == 0) ? 32'hFFFFFFFF : xs();
         @(posedge core_clk);
         chan_suspend_req <= m[NCH-1:0];
         @(posedge core_clk);
         chan_suspend_req <= '0;
         @(negedge core_clk);
         chk({8'h00, chan_suspended}, m);
         pulse_acc = '0;
         wr(RESUME_OFS, w);
         repeat (2) @(posedge core_clk);
         @(negedge core_clk);
         chk({8'h00, chan_suspended}, m & ~w & 32'h00FFFFFF);
         chk({8'h00, pulse_acc}, m & w & 32'h00FFFFFF);
         wr(RESUME_OFS, 32'hFFFFFFFF);
      end
      // One fetch per channel; low bits of the pointer are random, except bit 0 is 0 for channel 0 and 1 for channel 1
      for (i = 0; i < NCH; i++) begin
         d = xs();
         if (i < 2) d[0] = i[0];
         wr(ptr(i), d);
         rd(ptr(i), d & NDP_MASK);
         n0 = nfetch;
         pulse_req(24'h000001 << i);
         for (k = 0; k < 50 && nfetch == n0; k++) @(posedge core_clk);
         chk(32'(nfetch), 32'(n0 + 1));
         chk({31'h0, f_port}, {31'h0, d[PORT_SEL]});
         chk(f_addr, {d[31:2], 2'b00});
         chk({27'h0, f_chan}, 32'(i));
      end
      // Disabled channel fetches nothing
      i = int'(xs() % 32'd24);
      @(posedge core_clk);
      next_descriptor_fetch_enable <= ~(24'h000001 << i);
      n0 = nfetch;
      pulse_req(24'h000001 << i);
      repeat (10) @(posedge core_clk);
      chk(32'(nfetch), 32'(n0));
      chk({8'h00, fetch_pending}, 32'h00000000);
      next_descriptor_fetch_enable <= 24'hFFFFFF;
      // All channels at once while the interconnect stalls
      n0 = nfetch;
      pulse_req(24'hFFFFFF);
      for (k = 0; k < 400 && nfetch < n0 + NCH; k++) @(posedge core_clk);
      chk(32'(nfetch), 32'(n0 + NCH));
      // Byte lanes: only the low half of the pointer takes the write
      wr(ptr(0), 32'h00000000);
      avs_byteenable <= 4'h3;
      wr(ptr(0), 32'hFFFFFFFF);
      avs_byteenable <= 4'hF;
      rd(ptr(0), 32'h0000FFFF & NDP_MASK);
      wrap_up();
   end
endmodule
